// ==== core/sram_host_defs.vh ====
// Constants shared by the asynchronous static memory host controller.
`ifndef SRAM_HOST_DEFS_VH
`define SRAM_HOST_DEFS_VH
`define ADDR_W          18
`define DATA_W          16
`define LANE_W          2
`define CLK_PERIOD_NS   50
// Minimum cycle and write pulse times of the slowest grade, in ns.
`define T_RC_NS         20
`define T_WP1_NS        20
`define T_WC_NS         20
// Counts round up to whole cycles and add one more, so they are never below one.
`define RD_CYC          (((`T_RC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
`define WR_CYC          (((`T_WP1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
`define CNT_W           4
`endif

// ==== core/sram_host.v ====
// Host controller that reads and writes an asynchronous 256K x 16 static memory.
`timescale 1ns/1ps
`include "sram_host_defs.vh"
// Overview of operation
// - The host holds write enable high throughout every read.
// - A write happens only while select, write enable and a lane enable are low together.
// - The host never drives the data lines while the memory may be driving them.
// - The host presents a valid address no later than select falls.
module sram_host (
    input  wire                 i_core_clk,
    input  wire                 i_rst_n,
    input  wire                 i_req,
    input  wire                 i_we,
    input  wire [`ADDR_W-1:0]   i_addr,
    input  wire [`DATA_W-1:0]   i_wdata,
    input  wire [`LANE_W-1:0]   i_lane_en,
    input  wire [`DATA_W-1:0]   i_bus_in,
    output reg                  o_busy,
    output reg                  o_rvalid,
    output reg  [`DATA_W-1:0]   o_rdata,
    output reg  [`ADDR_W-1:0]   o_word_addr,
    output reg                  o_sel_n,
    output reg                  o_wr_en_n,
    output reg                  o_out_en_n,
    output reg                  o_low_lane_en_n,
    output reg                  o_high_lane_en_n,
    output reg  [`DATA_W-1:0]   o_bus_out,
    output reg                  o_bus_oe
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_RSEL  = 3'h1;
    localparam [2:0] ST_RWAIT = 3'h2;
    localparam [2:0] ST_WSET  = 3'h3;
    localparam [2:0] ST_WPUL  = 3'h4;
    localparam [2:0] ST_WEND  = 3'h5;
    // The cycle counts are cut to the counter width on purpose; both fit in it.
    localparam integer      RD_CYC_I = `RD_CYC;
    localparam integer      WR_CYC_I = `WR_CYC;
    localparam [`CNT_W-1:0] RD_CNT   = RD_CYC_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] WR_CNT   = WR_CYC_I[`CNT_W-1:0];

    // Read sequence, counted from the edge that takes the request.
    // At that edge the address is placed and the controller turns busy.
    // One edge later select, output enable and the lane pins fall together.
    // The count then runs down while the pins settle and cross the two-flop synchroniser.
    // At the last count the sampled lanes are stored, the valid pulse rises and all
    // strobes return high on the same edge.
    // Write sequence, counted the same way.
    // At the taking edge the address and the write data are placed.
    // One edge later select, write enable and the lane pins fall together while the
    // host drivers turn on, so the memory never sees a read condition.
    // Write enable rises after the count, which ends the write and latches the data.
    // One edge later select and the lane pins rise and the host drivers turn off.
    // A request is taken only while the sequencer is idle; requests that arrive while
    // busy are dropped, so the caller must watch the busy flag.
    // The read path spends two extra cycles in the synchroniser rather than trusting
    // the memory's access time, so the memory must present its data by the first edge
    // after select falls, where the first flop takes the only sample that is used.
    // The write data register stays loaded after a write, but the host drivers are off,
    // so the stale word never reaches the pins.

    reg [2:0]         state_r;
    reg [`CNT_W-1:0]  cnt_r;
    reg [`DATA_W-1:0] bus_s1_r;
    reg [`DATA_W-1:0] bus_s2_r;
    reg [`LANE_W-1:0] lane_r;

    // Turns the active-high lane request into the active-low lane pins; the read and
    // write phases share it so both drive the byte lanes the same way.
    function [`LANE_W-1:0] lanes_n;
        input [`LANE_W-1:0] lanes;
        begin
            lanes_n = ~lanes;
        end
    endfunction

    // True in the last wait cycle of a phase.
    function count_done;
        input [`CNT_W-1:0] count;
        begin
            count_done = (count == {`CNT_W{1'b0}});
        end
    endfunction

    // Wait counter step; it stops at zero so a stray state can never wrap it.
    function [`CNT_W-1:0] count_down;
        input [`CNT_W-1:0] count;
        begin
            if (count == {`CNT_W{1'b0}}) begin
                count_down = count;
            end else begin
                count_down = count - 4'h1;
            end
        end
    endfunction

    // Keeps the enabled byte lanes of the sampled pins and clears the others, because a
    // lane that the memory does not drive carries no meaning.
    function [`DATA_W-1:0] lane_keep;
        input [`LANE_W-1:0] lanes;
        input [`DATA_W-1:0] pins;
        begin
            lane_keep = {(lanes[1] ? pins[15:8] : 8'h00), (lanes[0] ? pins[7:0] : 8'h00)};
        end
    endfunction

    // The read data pins come from the asynchronous memory, so they pass two flops.
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_s1_r <= 16'h0000;
            bus_s2_r <= 16'h0000;
        end else begin
            bus_s1_r <= i_bus_in;
            bus_s2_r <= bus_s1_r;
        end
    end

    // Sequencer; strobes are all registered, so no pin glitches between phases.
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r          <= ST_IDLE;
            cnt_r            <= 4'h0;
            lane_r           <= 2'h0;
            o_busy           <= 1'b0;
            o_rvalid         <= 1'b0;
            o_rdata          <= 16'h0000;
            o_word_addr      <= 18'h00000;
            o_sel_n          <= 1'b1;
            o_wr_en_n        <= 1'b1;
            o_out_en_n       <= 1'b1;
            o_low_lane_en_n  <= 1'b1;
            o_high_lane_en_n <= 1'b1;
            o_bus_out        <= 16'h0000;
            o_bus_oe         <= 1'b0;
        end else begin
            o_rvalid <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    // A request with no lane enabled would do nothing, so it is ignored.
                    if (i_req && (i_lane_en != 2'h0)) begin
                        o_busy      <= 1'b1;
                        o_word_addr <= i_addr;
                        lane_r      <= i_lane_en;
                        if (i_we) begin
                            o_bus_out <= i_wdata;
                            state_r   <= ST_WSET;
                        end else begin
                            state_r <= ST_RSEL;
                        end
                    end
                end
                ST_RSEL: begin
                    // Address was set a cycle earlier, then select and output enable drop.
                    o_sel_n          <= 1'b0;
                    o_out_en_n       <= 1'b0;
                    o_wr_en_n        <= 1'b1;
                    {o_high_lane_en_n, o_low_lane_en_n} <= lanes_n(lane_r);
                    cnt_r            <= RD_CNT;
                    state_r          <= ST_RWAIT;
                end
                ST_RWAIT: begin
                    // Extra wait covers the two synchroniser stages on the data path.
                    if (count_done(cnt_r)) begin
                        o_rdata          <= lane_keep(lane_r, bus_s2_r);
                        o_rvalid         <= 1'b1;
                        o_sel_n          <= 1'b1;
                        o_out_en_n       <= 1'b1;
                        o_low_lane_en_n  <= 1'b1;
                        o_high_lane_en_n <= 1'b1;
                        o_busy           <= 1'b0;
                        state_r          <= ST_IDLE;
                    end else begin
                        cnt_r <= count_down(cnt_r);
                    end
                end
                ST_WSET: begin
                    // Output enable stays high and write enable falls with select, so the
                    // memory never drives; the host enables its drivers on that same edge.
                    o_out_en_n       <= 1'b1;
                    o_wr_en_n        <= 1'b0;
                    o_sel_n          <= 1'b0;
                    {o_high_lane_en_n, o_low_lane_en_n} <= lanes_n(lane_r);
                    o_bus_oe         <= 1'b1;
                    cnt_r            <= WR_CNT;
                    state_r          <= ST_WPUL;
                end
                ST_WPUL: begin
                    // Write enable rises first, so the write ends on it while select holds.
                    if (count_done(cnt_r)) begin
                        o_wr_en_n <= 1'b1;
                        state_r   <= ST_WEND;
                    end else begin
                        cnt_r <= count_down(cnt_r);
                    end
                end
                ST_WEND: begin
                    // Data and address are held one cycle past the write end for hold time.
                    o_sel_n          <= 1'b1;
                    o_low_lane_en_n  <= 1'b1;
                    o_high_lane_en_n <= 1'b1;
                    o_bus_oe         <= 1'b0;
                    o_busy           <= 1'b0;
                    state_r          <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
    // No refresh or memory clock is ever generated.
endmodule

// ==== verification/sram_host_sva.sv ====
// Pin-level checks on the static memory host controller.
`timescale 1ns/1ps
`include "sram_host_defs.vh"
module sram_host_sva (
    input wire logic                i_core_clk, i_rst_n, o_sel_n, o_wr_en_n, o_out_en_n,
    input wire logic                o_low_lane_en_n, o_high_lane_en_n, o_bus_oe, o_rvalid,
    input wire logic [`ADDR_W-1:0]  o_word_addr
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // A write strobe lasts three cycles and ends before select, so data is latched.
    sequence wr_pulse; !o_wr_en_n [*3] ##1 o_wr_en_n; endsequence
    sequence wr_frame; (!o_sel_n && o_bus_oe && !(o_low_lane_en_n && o_high_lane_en_n)) [*4];
    endsequence
    sequence rd_wait; !o_rvalid [*3] ##1 (o_rvalid && o_out_en_n); endsequence
    AST_RD_WE_HIGH: assert property (!o_sel_n && !o_out_en_n |-> o_wr_en_n)
        else $error("write strobe low during read");
    AST_WR_FRAME: assert property ($fell(o_wr_en_n) |-> wr_pulse and wr_frame)
        else $error("write frame broken");
    AST_NO_CONTENTION: assert property (o_bus_oe |-> o_out_en_n)
        else $error("host drives while memory may drive");
    AST_ADDR_HELD: assert property (!o_sel_n |-> $stable(o_word_addr))
        else $error("address moved while selected");
    AST_RD_ANSWER: assert property ($fell(o_out_en_n) |-> rd_wait)
        else $error("read answer late or early");
endmodule
bind sram_host sram_host_sva u_sram_host_sva (.i_core_clk, .i_rst_n, .o_sel_n, .o_wr_en_n,
    .o_out_en_n, .o_low_lane_en_n, .o_high_lane_en_n, .o_bus_oe, .o_rvalid, .o_word_addr);

// ==== verification/sram_model.sv ====
// Behavioural model of the asynchronous 256K x 16 static memory.
`timescale 1ns/1ps
module sram_model (
    input  wire logic [17:0] i_addr,
    input  wire logic        i_sel_n, i_wr_n, i_oe_n, i_lo_n, i_hi_n, i_host_oe,
    input  wire logic [15:0] i_host,
    output wire logic [15:0] o_bus
); // No clock and no refresh.
    logic [15:0] mem [0:262143];
    // Read drive only in the read condition and only on enabled lanes.
    wire rd = !i_sel_n && i_wr_n && !i_oe_n;
    wire [15:0] den = {{8{rd && !i_hi_n}}, {8{rd && !i_lo_n}}};
    // Undriven lanes show inverted data so a stale sample cannot pass.
    assign o_bus = i_host_oe ? i_host : (den & mem[i_addr]) | (~den & ~mem[i_addr]);
    // Data is latched when the first of select or strobe rises.
    always @(posedge i_wr_n or posedge i_sel_n) begin
        if (!i_sel_n || !i_wr_n) begin
            if (!i_lo_n) mem[i_addr][7:0] <= o_bus[7:0];
            if (!i_hi_n) mem[i_addr][15:8] <= o_bus[15:8];
        end
    end
endmodule

// ==== verification/sram_host_test.sv ====
// Self-checking bench for the static memory host controller.
`timescale 1ns/1ps
module sram_host_test;
    reg         clk = 0, rst_n = 0, req = 0, we = 0;
    reg  [17:0] addr = 18'h00000;
    reg  [15:0] wdata = 16'h0000, got;
    reg  [1:0]  lane = 2'h0;
    wire [15:0] bus, rdata, bus_out;
    wire [17:0] waddr;
    wire        busy, rvalid, sel_n, wr_n, oe_n, lo_n, hi_n, bus_oe;
    integer     error_cnt = 0, n_tests = 0, cyc = 0;
    sram_host u_sram_host (.i_core_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_we(we),
        .i_addr(addr), .i_wdata(wdata), .i_lane_en(lane), .i_bus_in(bus), .o_busy(busy),
        .o_rvalid(rvalid), .o_rdata(rdata), .o_word_addr(waddr), .o_sel_n(sel_n),
        .o_wr_en_n(wr_n), .o_out_en_n(oe_n), .o_low_lane_en_n(lo_n),
        .o_high_lane_en_n(hi_n), .o_bus_out(bus_out), .o_bus_oe(bus_oe));
    sram_model u_sram_model (.i_addr(waddr), .i_sel_n(sel_n), .i_wr_n(wr_n), .i_oe_n(oe_n),
        .i_lo_n(lo_n), .i_hi_n(hi_n), .i_host_oe(bus_oe), .i_host(bus_out), .o_bus(bus));
    initial forever #25 clk = ~clk;
    // A hang is cut short well beyond the fewer than a hundred cycles the tests need.
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish;
        end
    end
    task chk(input [15:0] e, input [15:0] g);
        n_tests = n_tests + 1;
        if (e !== g) begin
            $display("Error at %0t: expected %h got %h", $time, e, g);
            error_cnt = error_cnt + 1;
        end
    endtask
    // One request, then wait for idle; read data is taken in the valid cycle.
    task op(input w, input [17:0] a, input [15:0] d, input [1:0] l);
        integer k;
        got = 16'hXXXX;
        @(posedge clk); #1 {req, we, addr, wdata, lane} = {1'b1, w, a, d, l};
        @(posedge clk); #1 req = 0;
        @(posedge clk); #1;
        for (k = 0; k < 9 && busy === 1'b1; k = k + 1) begin
            @(posedge clk); #1;
            if (rvalid === 1'b1) got = rdata;
        end
    endtask
    task t_reset;
        chk(16'h0007, {12'h000, bus_oe, sel_n, wr_n, oe_n});
    endtask
    task t_full;
        op(1, 18'h3FFFF, 16'hA55A, 2'h3);
        op(0, 18'h3FFFF, 16'h0000, 2'h3);
        chk(16'hA55A, got);
    endtask
    task t_lanes;
        op(1, 18'h00010, 16'h1234, 2'h3);
        op(1, 18'h00010, 16'hFFCD, 2'h1);
        op(0, 18'h00010, 16'h0000, 2'h3);
        chk(16'h12CD, got);
        op(0, 18'h00010, 16'h0000, 2'h2);
        chk(16'h1200, got);
    endtask
    task t_refuse;
        op(1, 18'h00010, 16'h0000, 2'h0);
        op(0, 18'h00010, 16'h0000, 2'h3);
        chk(16'h12CD, got);
    endtask
    task t_b2b;
        op(1, 18'h00020, 16'h0F0F, 2'h3);
        op(1, 18'h00021, 16'hF0F0, 2'h3);
        op(0, 18'h00020, 16'h0000, 2'h3);
        chk(16'h0F0F, got);
        op(0, 18'h00021, 16'h0000, 2'h3);
        chk(16'hF0F0, got);
    endtask
    task tally_and_finish;
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Reset values are checked while reset is still held.
    initial begin
        repeat (12) @(posedge clk);
        #1 t_reset;
        rst_n = 1;
        t_full;
        t_lanes;
        t_refuse;
        t_b2b;
        tally_and_finish;
    end
endmodule
